//--- rtl/wsc_setup_core.v
// setup command executor for the wireless serial module, apb slave
`timescale 1ns/1ps
// Function
// - act on commands only in command mode
// - extended sniff: five decimal values, defaults
// - factory default restores settings, answers ok
// - scan timing: four values, 625 us units
// - binding 0 drop, 1 always; reset 0
// - drop-pairing forgets pairing on power cycle
// - always-paired talks only to bound peer
// - unbinding keeps stored peer address
// - forget-peer erases stored address, answers ok
// - version query reports firmware version
// - discovery reports each device, ends 30 s
// - discovery-complete message after last result
// - cancel stops discovery, ok then complete
// - peer address set and query
// - local address query reports own address
// - power saving 0 or 1, default 0
`include "wsc_consts.vh"
module wsc_setup_core #(
  parameter [31:0] MS_CYC = `WSC_CLK_HZ / `WSC_MS_PER_S, // cycles per ms
  parameter [31:0] DISC_MS = `WSC_T_DISC_S * `WSC_MS_PER_S, // search limit
  parameter [31:0] FW_VERSION = 32'h00010000, // arbitrary value
  parameter [47:0] LOCAL_ADDR = 48'h0a0b0c0d0e0f // arbitrary value
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output wire o_pready,
  output reg o_pslverr,
  input wire i_cmd_mode,
  input wire i_nv_bind,
  input wire i_nv_peer_valid,
  input wire [47:0] i_nv_peer_addr,
  input wire i_master_drop,
  input wire i_disc_found,
  input wire [47:0] i_found_addr,
  input wire [31:0] i_found_name,
  input wire i_disc_end,
  output wire o_disc_run,
  output wire o_bind,
  output wire o_peer_valid,
  output wire [47:0] o_peer_addr,
  output wire o_paired,
  output wire o_peer_only,
  output wire o_low_power,
  output wire [79:0] o_sniff_cfg,
  output wire [63:0] o_scan_cfg,
  output wire o_irq
);

  // executor states, one-hot
  localparam [2:0] ST_IDLE = 3'b001; // waiting for a command
  localparam [2:0] ST_DISC = 3'b010; // neighbour search running
  localparam [2:0] ST_FIN = 3'b100; // emit discovery-complete

  reg [2:0] st_q; // executor state
  reg [8:0] cmd_q; // last command word taken
  reg [31:0] arg_q [0:4]; // parameter words written by software
  reg [31:0] rep_q [0:4]; // report words read by software
  reg [15:0] sniff_q [0:4]; // max, min, attempt, over-time, timeout
  reg [15:0] scan_q [0:3]; // scan intv, scan tmo, inq intv, inq tmo
  reg [1:0] rc_q; // answer code of last command
  reg bind_q; // 1: always paired
  reg lowpwr_q; // power saving enable
  reg peer_ok_q; // stored peer address is valid
  reg [47:0] peer_q; // stored peer address
  reg paired_q; // current pairing permission
  reg load_q; // pending restore from non-volatile copy
  reg [31:0] tick_q; // cycle count within one ms
  reg [31:0] ms_q; // ms elapsed in the search
  reg [`WSC_NEV-1:0] ist_q; // sticky event flags
  reg [`WSC_NEV-1:0] imsk_q; // event mask
  reg [`WSC_NEV-1:0] ev; // events raised this cycle
  integer i; // loop index, executor only
  integer ai; // loop index of the range check
  integer bi; // loop index of the argument reset

  // access decode; every access completes with no wait state
  wire acc = i_psel & i_penable;
  wire wr = acc & i_pwrite;
  wire [3:0] op = i_pwdata[`WSC_OP_HI:0];
  wire qry = i_pwdata[`WSC_QRY_BIT];
  // a command write outside command mode is plain data: not acted on
  wire go = wr & (i_paddr == `WSC_A_CMD) & i_cmd_mode;
  wire arg_hit = (i_paddr >= `WSC_A_ARG0) & (i_paddr < `WSC_A_RESP);
  wire rep_hit = (i_paddr >= `WSC_A_REP0) & (i_paddr < `WSC_A_IST);
  wire [7:0] arg_off = i_paddr - `WSC_A_ARG0; // byte offset in arguments
  wire [7:0] rep_off = i_paddr - `WSC_A_REP0; // byte offset in reports
  wire [2:0] arg_ix = arg_off[4:2]; // word index, hit range keeps it < 5
  wire [2:0] rep_ix = rep_off[4:2]; // word index, hit range keeps it < 5
  wire search_end = (ms_q >= DISC_MS); // 30 s ceiling reached

  // any parameter word with a bit above bit 15 set is out of range
  reg wide_arg; // some argument too large
  always @* begin
    wide_arg = 1'b0;
    for (ai = 0; ai < `WSC_NARG; ai = ai + 1) begin
      if (arg_q[ai][31:16] != 16'h0000) begin
        wide_arg = 1'b1;
      end
    end
  end

  assign o_pready = 1'b1;

  // read mux and slave error for unmapped offsets
  always @* begin
    o_prdata = 32'h00000000;
    o_pslverr = 1'b0;
    if (arg_hit) begin
      o_prdata = arg_q[arg_ix];
    end else if (rep_hit) begin
      o_prdata = rep_q[rep_ix];
    end else begin
      case (i_paddr)
        `WSC_A_CMD: o_prdata = {23'h000000, cmd_q};
        `WSC_A_RESP: begin
          o_prdata[1:0] = rc_q;
          o_prdata[`WSC_RESP_BUSY] = ~st_q[0];
          o_prdata[`WSC_RESP_MODE] = i_cmd_mode;
        end
        `WSC_A_IST: o_prdata = {28'h0000000, ist_q};
        `WSC_A_IMSK: o_prdata = {28'h0000000, imsk_q};
        default: o_pslverr = acc; // unmapped: error, reads zero
      endcase
    end
  end

  // interrupt flags: the set wins over a clear in the same cycle
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      ist_q <= 4'h0;
      imsk_q <= 4'h0;
    end else begin
      if (wr & (i_paddr == `WSC_A_IMSK)) begin
        imsk_q <= i_pwdata[`WSC_NEV-1:0];
      end
      if (wr & (i_paddr == `WSC_A_IST)) begin
        ist_q <= (ist_q & ~i_pwdata[`WSC_NEV-1:0]) | ev;
      end else begin
        ist_q <= ist_q | ev;
      end
    end
  end

  assign o_irq = |(ist_q & imsk_q);

  // parameter words: plain storage, software owned
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      for (bi = 0; bi < `WSC_NARG; bi = bi + 1) begin
        arg_q[bi] <= 32'h00000000;
      end
    end else if (wr & arg_hit) begin
      arg_q[arg_ix] <= i_pwdata;
    end
  end

  // millisecond time base for the search limit; a prescaler counts ms,
  // though a raw 30 s count of 3750000000 cycles would also fit 32 bits
  always @(posedge i_clk) begin
    if (i_sys_rst | ~st_q[1]) begin
      tick_q <= 32'h00000000;
      ms_q <= 32'h00000000;
    end else if (tick_q == MS_CYC - 32'h00000001) begin
      tick_q <= 32'h00000000;
      ms_q <= ms_q + 32'h00000001;
    end else begin
      tick_q <= tick_q + 32'h00000001;
    end
  end

  // command executor, settings and discovery sequencing
  always @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_q <= ST_IDLE;
      cmd_q <= 9'h000;
      rc_q <= `WSC_RC_NONE;
      bind_q <= 1'b0;
      lowpwr_q <= 1'b0;
      peer_ok_q <= 1'b0;
      peer_q <= 48'h000000000000;
      paired_q <= 1'b0;
      load_q <= 1'b1;
      ev <= 4'h0;
      sniff_q[0] <= `WSC_SNIFF_MAX;
      sniff_q[1] <= `WSC_SNIFF_MIN;
      sniff_q[2] <= `WSC_SNIFF_TRY;
      sniff_q[3] <= `WSC_SNIFF_OVR;
      sniff_q[4] <= `WSC_SNIFF_TMO;
      scan_q[0] <= `WSC_SCAN_INTV;
      scan_q[1] <= `WSC_SCAN_TMO;
      scan_q[2] <= `WSC_SCAN_INTV;
      scan_q[3] <= `WSC_SCAN_TMO;
      for (i = 0; i < `WSC_NARG; i = i + 1) begin
        rep_q[i] <= 32'h00000000;
      end
    end else begin
      ev <= 4'h0;
      // restore the kept copy once after power-up; the pairing itself
      // survives only when binding was on
      if (load_q) begin
        load_q <= 1'b0;
        bind_q <= i_nv_bind;
        peer_ok_q <= i_nv_peer_valid;
        peer_q <= i_nv_peer_addr;
        paired_q <= i_nv_bind & i_nv_peer_valid;
      end
      // the master dropping the link ends a non-bound pairing
      if (i_master_drop & ~bind_q) begin
        paired_q <= 1'b0;
      end
      case (st_q)
        ST_IDLE: begin
          if (go) begin
            cmd_q <= i_pwdata[8:0];
            rc_q <= `WSC_RC_OK;
            ev[`WSC_EV_DONE] <= 1'b1;
            case (op)
              `WSC_OP_SNIFFX: begin
                if (qry) begin
                  for (i = 0; i < `WSC_NARG; i = i + 1) begin
                    rep_q[i] <= {16'h0000, sniff_q[i]};
                  end
                end else if (wide_arg |
                    (arg_q[1][15:0] > arg_q[0][15:0])) begin
                  rc_q <= `WSC_RC_ERR;
                  ev[`WSC_EV_ERR] <= 1'b1;
                end else begin
                  for (i = 0; i < `WSC_NARG; i = i + 1) begin
                    sniff_q[i] <= arg_q[i][15:0];
                  end
                end
              end
              `WSC_OP_FACTORY: begin
                sniff_q[0] <= `WSC_SNIFF_MAX;
                sniff_q[1] <= `WSC_SNIFF_MIN;
                sniff_q[2] <= `WSC_SNIFF_TRY;
                sniff_q[3] <= `WSC_SNIFF_OVR;
                sniff_q[4] <= `WSC_SNIFF_TMO;
                scan_q[0] <= `WSC_SCAN_INTV;
                scan_q[1] <= `WSC_SCAN_TMO;
                scan_q[2] <= `WSC_SCAN_INTV;
                scan_q[3] <= `WSC_SCAN_TMO;
                bind_q <= 1'b0;
                lowpwr_q <= 1'b0;
                peer_ok_q <= 1'b0;
                peer_q <= 48'h000000000000;
                paired_q <= 1'b0;
              end
              `WSC_OP_SCAN: begin
                if (qry) begin
                  for (i = 0; i < 4; i = i + 1) begin
                    rep_q[i] <= {16'h0000, scan_q[i]};
                  end
                end else if (wide_arg) begin
                  rc_q <= `WSC_RC_ERR;
                  ev[`WSC_EV_ERR] <= 1'b1;
                end else begin
                  for (i = 0; i < 4; i = i + 1) begin
                    scan_q[i] <= arg_q[i][15:0];
                  end
                end
              end
              `WSC_OP_BIND: begin
                if (qry) begin
                  rep_q[0] <= {31'h00000000, bind_q};
                end else if (arg_q[0] > 32'h00000001) begin
                  rc_q <= `WSC_RC_ERR;
                  ev[`WSC_EV_ERR] <= 1'b1;
                end else begin
                  bind_q <= arg_q[0][0];
                  // the address is kept either way, so binding again
                  // reconnects to the same peer
                  if (arg_q[0][0] & peer_ok_q) begin
                    paired_q <= 1'b1;
                  end
                end
              end
              `WSC_OP_FORGET: begin
                peer_ok_q <= 1'b0;
                peer_q <= 48'h000000000000;
                paired_q <= 1'b0;
              end
              `WSC_OP_VERSION: begin
                rep_q[0] <= FW_VERSION;
              end
              `WSC_OP_DISC: begin
                st_q <= ST_DISC;
              end
              `WSC_OP_CANCEL: begin
                // nothing to stop: still answer and close cleanly
                st_q <= ST_FIN;
              end
              `WSC_OP_PEER: begin
                if (qry) begin
                  rep_q[0] <= peer_q[31:0];
                  rep_q[1] <= {16'h0000, peer_q[47:32]};
                end else if (arg_q[1][31:16] != 16'h0000) begin
                  rc_q <= `WSC_RC_ERR;
                  ev[`WSC_EV_ERR] <= 1'b1;
                end else begin
                  peer_q <= {arg_q[1][15:0], arg_q[0]};
                  peer_ok_q <= 1'b1;
                  paired_q <= 1'b1;
                end
              end
              `WSC_OP_LOCAL_ADDRESS_CMD: begin
                rep_q[0] <= LOCAL_ADDR[31:0];
                rep_q[1] <= {16'h0000, LOCAL_ADDR[47:32]};
              end
              `WSC_OP_LOWPWR: begin
                if (qry) begin
                  rep_q[0] <= {31'h00000000, lowpwr_q};
                end else if (arg_q[0] > 32'h00000001) begin
                  rc_q <= `WSC_RC_ERR;
                  ev[`WSC_EV_ERR] <= 1'b1;
                end else begin
                  lowpwr_q <= arg_q[0][0];
                end
              end
              default: begin
                rc_q <= `WSC_RC_ERR;
                ev[`WSC_EV_ERR] <= 1'b1;
              end
            endcase
          end
        end
        ST_DISC: begin
          // each neighbour found becomes one result in the report words
          if (i_disc_found) begin
            rep_q[0] <= i_found_addr[31:0];
            rep_q[1] <= {16'h0000, i_found_addr[47:32]};
            rep_q[2] <= i_found_name;
            ev[`WSC_EV_FOUND] <= 1'b1;
          end
          if (go) begin
            cmd_q <= i_pwdata[8:0];
            ev[`WSC_EV_DONE] <= 1'b1;
            if ((op == `WSC_OP_CANCEL) & ~qry) begin
              rc_q <= `WSC_RC_OK;
              st_q <= ST_FIN;
            end else begin
              // only cancel is served while the search runs
              rc_q <= `WSC_RC_ERR;
              ev[`WSC_EV_ERR] <= 1'b1;
            end
          end
          // a command in the same cycle must not swallow the radio's end
          if (i_disc_end | search_end) begin
            st_q <= ST_FIN;
          end
        end
        ST_FIN: begin
          ev[`WSC_EV_DCOMP] <= 1'b1;
          st_q <= ST_IDLE;
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign o_disc_run = st_q[1];
  assign o_bind = bind_q;
  assign o_peer_valid = peer_ok_q;
  assign o_peer_addr = peer_q;
  assign o_paired = paired_q;
  // bound and addressed: the link may serve only this peer
  assign o_peer_only = bind_q & peer_ok_q;
  assign o_low_power = lowpwr_q;
  assign o_sniff_cfg = {sniff_q[4], sniff_q[3], sniff_q[2], sniff_q[1],
    sniff_q[0]};
  assign o_scan_cfg = {scan_q[3], scan_q[2], scan_q[1], scan_q[0]};

endmodule // wsc_setup_core

//--- shared/wsc_consts.vh
// constants for the wireless serial setup command block
`ifndef WSC_CONSTS_VH
`define WSC_CONSTS_VH
// register byte offsets (apb, one 32-bit word each)
`define WSC_A_CMD 8'h00
`define WSC_A_ARG0 8'h04
`define WSC_A_RESP 8'h18
`define WSC_A_REP0 8'h1c
`define WSC_A_IST 8'h30
`define WSC_A_IMSK 8'h34
`define WSC_NARG 5
// command word fields
`define WSC_OP_HI 3
`define WSC_QRY_BIT 8
// opcodes
`define WSC_OP_SNIFFX 4'h1
`define WSC_OP_FACTORY 4'h2
`define WSC_OP_SCAN 4'h3
`define WSC_OP_BIND 4'h4
`define WSC_OP_FORGET 4'h5
`define WSC_OP_VERSION 4'h6
`define WSC_OP_DISC 4'h7
`define WSC_OP_CANCEL 4'h8
`define WSC_OP_PEER 4'h9
`define WSC_OP_LOCAL_ADDRESS_CMD 4'ha
`define WSC_OP_LOWPWR 4'hb
// answer codes held in the response register
`define WSC_RC_NONE 2'h0
`define WSC_RC_OK 2'h1
`define WSC_RC_ERR 2'h2
`define WSC_RESP_BUSY 8
`define WSC_RESP_MODE 9
// interrupt status bits
`define WSC_EV_DONE 0
`define WSC_EV_FOUND 1
`define WSC_EV_DCOMP 2
`define WSC_EV_ERR 3
`define WSC_NEV 4
// factory values
`define WSC_SNIFF_MAX 16'h0400
`define WSC_SNIFF_MIN 16'h0200
`define WSC_SNIFF_TRY 16'h0400
`define WSC_SNIFF_OVR 16'h0200
`define WSC_SNIFF_TMO 16'h000a
`define WSC_SCAN_INTV 16'h0800
`define WSC_SCAN_TMO 16'h0012
// timing: clock rate and discovery limit
`define WSC_CLK_HZ 125000000
`define WSC_MS_PER_S 1000
`define WSC_T_DISC_S 30
`endif

//--- verification/wsc_setup_properties.sv
// port-level checker for the setup command block, bound to the core
`timescale 1ns/1ps
`include "wsc_consts.vh"
module wsc_setup_chk #(
  parameter [31:0] MS_CYC = 4, // cycles per ms, as on the core
  parameter [31:0] DISC_MS = 5 // search limit in ms, as on the core
) (
  input wire i_clk,
  input wire i_sys_rst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [7:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire o_pready,
  input wire o_pslverr,
  input wire i_cmd_mode,
  input wire i_disc_end,
  input wire o_disc_run,
  input wire o_bind,
  input wire o_peer_valid,
  input wire o_peer_only,
  input wire o_low_power
);
  wire acc = i_psel && i_penable; // access phase
  wire cmd_wr = acc && i_pwrite && i_paddr == `WSC_A_CMD; // command write
  wire cmd_go = cmd_wr && i_cmd_mode && !o_disc_run; // command that acts
  wire [3:0] op = i_pwdata[3:0]; // opcode field
  wire qry = i_pwdata[`WSC_QRY_BIT]; // query form
  reg [31:0] arg0_q; // shadow of the first argument word
  reg [31:0] run_q; // cycles spent searching
  // shadow ARG0 so settings can be tied to the value software gave
  always @(posedge i_clk) begin
    if (i_sys_rst) arg0_q <= 32'h0;
    else if (acc && i_pwrite && i_paddr == `WSC_A_ARG0) arg0_q <= i_pwdata;
  end
  // search length counter; a counter keeps the 30 s bound cheap to check
  always @(posedge i_clk) begin
    if (i_sys_rst || !o_disc_run) run_q <= 32'h0;
    else run_q <= run_q + 32'h1;
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  pready_high_a: assert property (o_pready)
    else $error("pready low");
  unmapped_err_a: assert property (acc && i_paddr > 8'h34 |-> o_pslverr)
    else $error("no slave error on unmapped address");
  peer_only_a: assert property (o_peer_only == (o_bind && o_peer_valid))
    else $error("peer restriction not bind and valid");
  mode_gate_a: assert property (cmd_wr && !i_cmd_mode |=>
    $stable(o_bind) && $stable(o_low_power) && !$rose(o_disc_run))
    else $error("command acted outside command mode");
  power_set_a: assert property (cmd_go && op == `WSC_OP_LOWPWR && !qry
    && arg0_q <= 32'h1 |=> o_low_power == arg0_q[0])
    else $error("power saving not taken");
  bind_set_a: assert property (cmd_go && op == `WSC_OP_BIND && !qry
    && arg0_q <= 32'h1 |=> o_bind == arg0_q[0])
    else $error("binding not taken");
  forget_clear_a: assert property (cmd_go && op == `WSC_OP_FORGET
    |=> !o_peer_valid) else $error("peer kept after forget");
  factory_reset_a: assert property (cmd_go && op == `WSC_OP_FACTORY
    |=> !o_bind && !o_low_power && !o_peer_valid)
    else $error("factory values not restored");
  disc_start_a: assert property (cmd_go && op == `WSC_OP_DISC |=> o_disc_run)
    else $error("search did not start");
  disc_end_a: assert property (o_disc_run && i_disc_end |=> !o_disc_run)
    else $error("search ran past radio end");
  disc_limit_a: assert property (run_q <= MS_CYC * DISC_MS + 32'h1)
    else $error("search ran past its limit");
  cover property (cmd_go && op == `WSC_OP_DISC);
  cover property ($fell(o_disc_run));
  cover property (acc && o_pslverr);
endmodule // wsc_setup_chk
bind wsc_setup_core wsc_setup_chk #(.MS_CYC(MS_CYC), .DISC_MS(DISC_MS)) u_chk (
  .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(i_psel),
  .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
  .i_pwdata(i_pwdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
  .i_cmd_mode(i_cmd_mode), .i_disc_end(i_disc_end), .o_disc_run(o_disc_run),
  .o_bind(o_bind), .o_peer_valid(o_peer_valid), .o_peer_only(o_peer_only),
  .o_low_power(o_low_power));

//--- verification/wsc_radio_model.sv
// radio partner model: answers a running search with results and an end
`timescale 1ns/1ps
module wsc_radio_model (
  input wire i_clk,
  input wire i_run,
  input wire [3:0] i_results,
  input wire i_hold,
  output reg o_found,
  output reg [47:0] o_addr,
  output reg [31:0] o_name,
  output reg o_end
);
  integer k; // result index
  // behavioural radio; hold withholds the end so cancel and timeout can win
  initial begin
    o_found = 1'b0;
    o_end = 1'b0;
    o_addr = 48'h0;
    o_name = 32'h0;
    forever begin
      @(posedge i_clk);
      if (i_run) begin
        for (k = 1; k <= i_results; k = k + 1) begin
          repeat (2) @(posedge i_clk);
          o_found <= 1'b1;
          o_addr <= {16'h0a0b, 28'h0, k[3:0]};
          o_name <= 32'h6e6d0000 + k;
          @(posedge i_clk);
          o_found <= 1'b0;
          // result lines are stale now; show a changed pattern, not zero
          o_addr <= ~{16'h0a0b, 28'h0, k[3:0]};
          o_name <= ~(32'h6e6d0000 + k);
        end
        if (!i_hold) begin
          @(posedge i_clk);
          o_end <= 1'b1;
          @(posedge i_clk);
          o_end <= 1'b0;
        end
        while (i_run) @(posedge i_clk);
      end
    end
  end
endmodule // wsc_radio_model

//--- verification/tb_top.sv
// self-checking bench for the setup command block
`timescale 1ns/1ps
`include "wsc_consts.vh"
module tb_top;
  localparam [31:0] FW = 32'h00020003; // arbitrary value
  localparam [47:0] LA = 48'h112233445566; // arbitrary value
  localparam [47:0] NVA = 48'h0c0d01020304; // kept peer for power cycle
  reg i_clk, i_sys_rst, psel, penable, pwrite, cmd_mode, nv_bind, nv_pv;
  reg drop, hold, err_q;
  reg [7:0] paddr;
  reg [31:0] pwdata, rd_q;
  reg [3:0] nres;
  wire [31:0] prdata, fname;
  wire pready, pslverr, found, dend, run, bnd, pv, paired, ponly, lp, irq;
  wire [47:0] fa, peer;
  wire [79:0] sniff;
  wire [63:0] scan;
  integer error_cnt, total_checks, cyc, i;
  wsc_setup_core #(.MS_CYC(4), .DISC_MS(20), .FW_VERSION(FW),
    .LOCAL_ADDR(LA)) dut (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_cmd_mode(cmd_mode), .i_nv_bind(nv_bind),
    .i_nv_peer_valid(nv_pv), .i_nv_peer_addr(NVA), .i_master_drop(drop),
    .i_disc_found(found), .i_found_addr(fa), .i_found_name(fname),
    .i_disc_end(dend), .o_disc_run(run), .o_bind(bnd), .o_peer_valid(pv),
    .o_peer_addr(peer), .o_paired(paired), .o_peer_only(ponly),
    .o_low_power(lp), .o_sniff_cfg(sniff), .o_scan_cfg(scan), .o_irq(irq));
  wsc_radio_model radio (.i_clk(i_clk), .i_run(run), .i_results(nres),
    .i_hold(hold), .o_found(found), .o_addr(fa), .o_name(fname),
    .o_end(dend));
  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end
  // take read data and error at the edge that completes the access
  always @(posedge i_clk) begin
    if (psel && penable && pready) begin
      rd_q <= prdata;
      err_q <= pslverr;
    end
  end
  // hang guard: a run this long means a wait never ended
  always @(posedge i_clk) begin
    cyc = cyc + 1;
    if (cyc > 20000) begin
      error_cnt = error_cnt + 1;
      give_verdict;
    end
  end
  task chk(input [79:0] seen, input [79:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one apb transfer; request held until pready is seen at an edge
  task apb(input w, input [7:0] a, input [31:0] d);
    @(posedge i_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    // pready is judged inside the access cycle, so the next edge is the
    // one at which the slave is seen ready
    #1;
    while (!pready) begin
      @(posedge i_clk);
      #1;
    end
    @(posedge i_clk);
    psel <= 1'b0; penable <= 1'b0;
    #1;
  endtask
  // arguments first, then the command word, then read the answer code
  task cmd(input [8:0] c, input [31:0] a0, input [31:0] a1);
    apb(1'b1, `WSC_A_ARG0, a0);
    apb(1'b1, 8'h08, a1);
    apb(1'b1, `WSC_A_CMD, {23'h0, c});
    apb(1'b0, `WSC_A_RESP, 32'h0);
  endtask
  task do_reset;
    @(posedge i_clk);
    i_sys_rst <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(posedge i_clk);
    #1;
  endtask
  task wait_idle;
    integer n;
    n = 0;
    while (run && n < 200) begin
      @(posedge i_clk);
      n = n + 1;
    end
    #1;
  endtask
  task t_defaults;
    reg [79:0] e;
    e = {16'd10, 16'd512, 16'd1024, 16'd512, 16'd1024};
    chk(sniff, e);
    chk(scan, {16'd18, 16'd2048, 16'd18, 16'd2048});
    chk({bnd, lp}, 2'b00);
    cmd({5'h10, `WSC_OP_SNIFFX}, 32'h0, 32'h0);
    chk(rd_q[1:0], `WSC_RC_OK);
    for (i = 0; i < 5; i = i + 1) begin
      apb(1'b0, `WSC_A_REP0 + 4 * i, 32'h0);
      chk(rd_q, e[16 * i +: 16]);
    end
    apb(1'b0, 8'h40, 32'h0);
    chk({err_q, rd_q}, {1'b1, 32'h0});
    cmd_mode <= 1'b0;
    cmd({5'h0, `WSC_OP_LOWPWR}, 32'h1, 32'h0);
    chk({lp, rd_q[1:0]}, {1'b0, `WSC_RC_OK});
    cmd_mode <= 1'b1;
    $display("test defaults done");
  endtask
  task t_settings;
    apb(1'b1, 8'h0c, 32'd300);
    apb(1'b1, 8'h10, 32'd400);
    apb(1'b1, 8'h14, 32'd20);
    cmd({5'h0, `WSC_OP_SNIFFX}, 32'd2000, 32'd100);
    chk(sniff, {16'd20, 16'd400, 16'd300, 16'd100, 16'd2000});
    cmd({5'h0, `WSC_OP_SNIFFX}, 32'd50, 32'd100);
    chk({rd_q[1:0], sniff[15:0]}, {`WSC_RC_ERR, 16'd2000});
    apb(1'b1, 8'h0c, 32'd200);
    apb(1'b1, 8'h10, 32'd6);
    cmd({5'h0, `WSC_OP_SCAN}, 32'd100, 32'd5);
    chk(scan, {16'd6, 16'd200, 16'd5, 16'd100});
    cmd({5'h0, `WSC_OP_LOWPWR}, 32'h1, 32'h0);
    chk(lp, 1'b1);
    cmd({5'h0, `WSC_OP_LOWPWR}, 32'h2, 32'h0);
    chk({rd_q[1:0], lp}, {`WSC_RC_ERR, 1'b1});
    cmd({5'h10, `WSC_OP_LOWPWR}, 32'h0, 32'h0);
    apb(1'b0, `WSC_A_REP0, 32'h0);
    chk(rd_q, 32'h1);
    cmd({5'h0, 4'hf}, 32'h0, 32'h0);
    chk(rd_q[1:0], `WSC_RC_ERR);
    cmd({5'h0, `WSC_OP_VERSION}, 32'h0, 32'h0);
    apb(1'b0, `WSC_A_REP0, 32'h0);
    chk(rd_q, FW);
    cmd({5'h10, `WSC_OP_LOCAL_ADDRESS_CMD}, 32'h0, 32'h0);
    apb(1'b0, `WSC_A_REP0, 32'h0);
    chk(rd_q, LA[31:0]);
    apb(1'b0, 8'h20, 32'h0);
    chk(rd_q, {16'h0, LA[47:32]});
    cmd({5'h0, `WSC_OP_FACTORY}, 32'h0, 32'h0);
    chk({rd_q[1:0], lp, sniff[15:0]}, {`WSC_RC_OK, 1'b0, 16'd1024});
    $display("test settings done");
  endtask
  task t_pair;
    cmd({5'h0, `WSC_OP_PEER}, 32'h0e0f1011, 32'h0a0b);
    chk({peer, paired}, {48'h0a0b0e0f1011, 1'b1});
    cmd({5'h10, `WSC_OP_PEER}, 32'h0, 32'h0);
    apb(1'b0, `WSC_A_REP0, 32'h0);
    chk(rd_q, 32'h0e0f1011);
    cmd({5'h0, `WSC_OP_BIND}, 32'h1, 32'h0);
    drop <= 1'b1;
    @(posedge i_clk);
    drop <= 1'b0;
    @(posedge i_clk);
    #1;
    chk({ponly, paired}, 2'b11);
    cmd({5'h0, `WSC_OP_BIND}, 32'h0, 32'h0);
    drop <= 1'b1;
    @(posedge i_clk);
    drop <= 1'b0;
    @(posedge i_clk);
    #1;
    chk({pv, paired}, 2'b10);
    cmd({5'h0, `WSC_OP_BIND}, 32'h1, 32'h0);
    chk({ponly, peer}, {1'b1, 48'h0a0b0e0f1011});
    cmd({5'h0, `WSC_OP_FORGET}, 32'h0, 32'h0);
    chk({rd_q[1:0], pv, ponly}, {`WSC_RC_OK, 2'b00});
    nv_bind <= 1'b1;
    nv_pv <= 1'b1;
    do_reset;
    chk({ponly, peer}, {1'b1, NVA});
    nv_bind <= 1'b0;
    nv_pv <= 1'b0;
    do_reset;
    chk({pv, paired}, 2'b00);
    $display("test pairing done");
  endtask
  task t_disc;
    apb(1'b1, `WSC_A_IMSK, 32'hf);
    nres <= 4'h2;
    hold <= 1'b0;
    cmd({5'h0, `WSC_OP_DISC}, 32'h0, 32'h0);
    chk(rd_q[1:0], `WSC_RC_OK);
    wait_idle;
    apb(1'b0, `WSC_A_REP0, 32'h0);
    chk(rd_q, 32'h2);
    apb(1'b0, 8'h24, 32'h0);
    chk(rd_q, 32'h6e6d0002);
    apb(1'b0, `WSC_A_IST, 32'h0);
    chk({rd_q[2:1], irq}, 3'b111);
    apb(1'b1, `WSC_A_IMSK, 32'h0);
    chk(irq, 1'b0);
    apb(1'b1, `WSC_A_IST, 32'hf);
    apb(1'b1, `WSC_A_IMSK, 32'hf);
    chk(irq, 1'b0);
    nres <= 4'h0;
    hold <= 1'b1;
    cmd({5'h0, `WSC_OP_DISC}, 32'h0, 32'h0);
    chk(run, 1'b1);
    cmd({5'h0, `WSC_OP_PEER}, 32'h1, 32'h0);
    chk(rd_q[1:0], `WSC_RC_ERR);
    cmd({5'h0, `WSC_OP_CANCEL}, 32'h0, 32'h0);
    chk(rd_q[1:0], `WSC_RC_OK);
    repeat (3) @(posedge i_clk);
    apb(1'b0, `WSC_A_IST, 32'h0);
    chk({run, rd_q[2]}, 2'b01);
    cmd({5'h0, `WSC_OP_DISC}, 32'h0, 32'h0);
    repeat (80) @(posedge i_clk);
    #1;
    chk(run, 1'b0);
    $display("test discovery done");
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    error_cnt = 0; total_checks = 0; cyc = 0;
    i_sys_rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h0; pwdata = 32'h0; cmd_mode = 1'b1; nv_bind = 1'b0;
    nv_pv = 1'b0; drop = 1'b0; hold = 1'b0; nres = 4'h0;
    do_reset;
    t_defaults;
    t_settings;
    t_pair;
    t_disc;
    give_verdict;
  end
endmodule // tb_top
